// ==== verif/dbgent_entry_tb.sv ====
// Purpose: Self-checking bench for the debug entry handshake.
// Assumes: Window shortened to keep the run brief.
// Notes:   Each test starts from a fresh power-up reset.
`timescale 1ns/100ps
module dbgent_entry_tb;
	localparam int WIN = 170000;
	logic       clk;
	logic       rstn;
	logic       selftest_done;
	logic       dbg_rxd;
	logic       dbg_txd;
	logic       debug_mode;
	logic       script_halt;
	logic       entry_done;
	logic [7:0] rx_byte;
	logic [7:0] junk;
	int         rx_cnt;
	int         rx_bad;
	int         base;
	int         n_fail;
	int         comparisons;
	int         cyc;
	int         t0;
	int         seed;

	dbgent_entry #(.WINDOW_CYCLES(WIN)) DUT (
		.clk(clk), .rstn(rstn), .selftest_done(selftest_done),
		.dbg_rxd(dbg_rxd), .dbg_txd(dbg_txd), .debug_mode(debug_mode),
		.script_halt(script_halt), .entry_done(entry_done));
	dbgent_host host (
		.clk(clk), .dbg_txd(dbg_txd), .dbg_rxd(dbg_rxd),
		.rx_byte(rx_byte), .rx_cnt(rx_cnt), .rx_bad(rx_bad));

	initial clk = 1'b0;
	always #10 clk = ~clk;

	// Both tests together take about 330000 cycles.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 400000) begin
			n_fail++;
			end_sim();
		end
	end

	task automatic check(input string nm, input logic [7:0] seen,
	                     input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic power_up();
		@(negedge clk);
		rstn = 1'b0;
		selftest_done = 1'b0;
		repeat (3) @(negedge clk);
		rstn = 1'b1;
		repeat (($random(seed) & 15) + 4) @(negedge clk);
		base = rx_cnt;
		selftest_done = 1'b1;
		t0 = cyc;
		for (int i = 0; i < 60000 && rx_cnt == base; i++) @(negedge clk);
		check("announce", rx_byte, dbgent_pkg::ANNOUNCE_BYTE);
		check("announce_count", 8'(rx_cnt - base), 8'h01);
		check("announce_frame", 8'(rx_bad), 8'h00);
		check("early_done", {7'h00, entry_done}, 8'h00);
	endtask

	// Entry is due only for the right byte, a good stop bit and in time.
	function automatic logic [7:0] exp_mode(input logic [7:0] b,
	                                        input logic       stop,
	                                        input logic       in_win);
		return {7'h00, b == dbgent_pkg::ACK_BYTE && stop && in_win};
	endfunction

	task automatic end_sim();
		$display("comparisons %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		seed = 98989;
		rstn = 1'b0;
		selftest_done = 1'b0;
		power_up();
		host.send_byte(dbgent_pkg::ACK_BYTE, 1'b1);
		check("debug_mode", {7'h00, debug_mode},
		      exp_mode(dbgent_pkg::ACK_BYTE, 1'b1, 1'b1));
		check("script_halt", {7'h00, script_halt},
		      exp_mode(dbgent_pkg::ACK_BYTE, 1'b1, 1'b1));
		check("entry_done", {7'h00, entry_done}, 8'h01);
		repeat (1000) @(negedge clk);
		check("byte_count", 8'(rx_cnt - base), 8'h01);
		$display("test ack done");
		power_up();
		junk = 8'($random(seed));
		if (junk == dbgent_pkg::ACK_BYTE) begin
			junk = 8'h4e;
		end
		host.send_byte(junk, 1'b1);
		check("wrong_byte", {7'h00, debug_mode},
		      exp_mode(junk, 1'b1, 1'b1));
		host.send_byte(dbgent_pkg::ACK_BYTE, 1'b0);
		check("bad_stop", {7'h00, debug_mode},
		      exp_mode(dbgent_pkg::ACK_BYTE, 1'b0, 1'b1));
		while (entry_done !== 1'b1 && cyc - t0 < WIN + 100) @(negedge clk);
		check("window", {7'h00, (cyc - t0 >= WIN && cyc - t0 <= WIN + 8)},
		      8'h01);
		check("timeout_halt", {7'h00, script_halt}, 8'h00);
		host.send_byte(dbgent_pkg::ACK_BYTE, 1'b1);
		check("late_ack", {7'h00, debug_mode},
		      exp_mode(dbgent_pkg::ACK_BYTE, 1'b1, 1'b0));
		check("byte_count", 8'(rx_cnt - base), 8'h01);
		$display("test timeout done");
		end_sim();
	end
endmodule // dbgent_entry_tb

// ==== verif/dbgent_host.sv ====
// Purpose: Host serial port model on the debug pins.
// Assumes: Same 8N1 framing and rate as the device.
// Notes:   The bench calls send_byte; received bytes are counted.
`timescale 1ns/100ps
module dbgent_host (
	// Clock
	input  wire logic       clk,
	// Serial pins
	input  wire logic       dbg_txd,
	output logic            dbg_rxd,
	// Receive report
	output logic [7:0]      rx_byte,
	output int              rx_cnt,
	output int              rx_bad
);
	initial begin
		dbg_rxd = 1'b1;
		rx_byte = 8'h00;
		rx_cnt  = 0;
		rx_bad  = 0;
	end

	// No flow control lines exist, so the host sends whenever asked.
	task automatic send_byte(input logic [7:0] d, input logic stop);
		logic [9:0] f;
		f = {stop, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(negedge clk) dbg_rxd = f[i];
			repeat (dbgent_pkg::BIT_CYC - 1) @(negedge clk);
		end
		@(negedge clk) dbg_rxd = 1'b1;
	endtask

	// Mid-bit sampling; a wrong rate shows as a bad start or stop bit.
	always begin
		@(negedge dbg_txd);
		repeat (dbgent_pkg::HALF_CYC) @(posedge clk);
		if (dbg_txd !== 1'b0) rx_bad++;
		for (int i = 0; i < 8; i++) begin
			repeat (dbgent_pkg::BIT_CYC) @(posedge clk);
			rx_byte[i] = dbg_txd;
		end
		repeat (dbgent_pkg::BIT_CYC) @(posedge clk);
		if (dbg_txd !== 1'b1) rx_bad++;
		rx_cnt++;
	end
endmodule // dbgent_host

// ==== verilog/dbgent_entry.sv ====
// Purpose: Power-up debug entry handshake on the debug serial port.
// Assumes: Self-test completion arrives as a level from same-clock logic.
// Notes:   Decision is made once per reset; only power-up re-arms it.
`timescale 1ns/100ps
module dbgent_entry #(
	parameter int unsigned WINDOW_CYCLES = dbgent_pkg::WINDOW_CYC
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rstn,
	// System status
	input  wire logic selftest_done,
	// Debug serial pins
	input  wire logic dbg_rxd,
	output wire logic dbg_txd,
	// Mode outputs
	output logic      debug_mode,
	output logic      script_halt,
	output logic      entry_done
);

	// ------------------------------------------------------------
	// Reset and pin synchronisers
	// ------------------------------------------------------------
	logic [1:0] rst_sync_q;
	logic       rst_n;
	logic       rx_meta_q;
	logic       rx_q;

	// The receive pin follows the host's own clock, so two flops guard it.
	assign rst_n = rst_sync_q[1];

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_meta_q <= 1'b1;
			rx_q      <= 1'b1;
		end else begin
			rx_meta_q <= dbg_rxd;
			rx_q      <= rx_meta_q;
		end
	end

	// ------------------------------------------------------------
	// Transceiver
	// ------------------------------------------------------------
	dbgent_pkg::dbgent_rx_t rx;
	dbgent_pkg::dbgent_state_t state_q;
	dbgent_pkg::dbgent_state_t state_d;
	logic        tx_busy;
	logic        sent_q;
	logic [24:0] win_q;

	wire tx_go = (state_q == dbgent_pkg::DBGENT_ANNOUNCE) && !sent_q;

	dbgent_uart u_uart (
		.clk      (clk),
		.rst_n    (rst_n),
		.tx_start (tx_go),
		.tx_data  (dbgent_pkg::ANNOUNCE_BYTE),
		.tx_busy  (tx_busy),
		.tx_line  (dbg_txd),
		.rx_line  (rx_q),
		.rx_out   (rx)
	);

	// ------------------------------------------------------------
	// Entry sequence
	// ------------------------------------------------------------
	// The window opens at the start bit of the announcement; the host
	// is expected to run the same 8N1 rate with flow control off.
	localparam logic [24:0] WIN_LAST = 25'(WINDOW_CYCLES - 1);
	wire ack_ok = rx.valid && !rx.frame_err
	              && (rx.data == dbgent_pkg::ACK_BYTE);
	wire win_end = (win_q == WIN_LAST);

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			dbgent_pkg::DBGENT_WAIT_TEST: begin
				if (selftest_done) begin
					state_d = dbgent_pkg::DBGENT_ANNOUNCE;
				end
			end
			dbgent_pkg::DBGENT_ANNOUNCE: begin
				if (sent_q) begin
					state_d = dbgent_pkg::DBGENT_LISTEN;
				end
			end
			dbgent_pkg::DBGENT_LISTEN: begin
				if (ack_ok || win_end) begin
					state_d = dbgent_pkg::DBGENT_DONE;
				end
			end
			dbgent_pkg::DBGENT_DONE: begin
				state_d = dbgent_pkg::DBGENT_DONE;
			end
			default: begin
				state_d = dbgent_pkg::DBGENT_DONE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= dbgent_pkg::DBGENT_WAIT_TEST;
			sent_q  <= 1'b0;
			win_q   <= 25'h0000000;
		end else begin
			state_q <= state_d;
			if (tx_go) begin
				sent_q <= 1'b1;
			end
			if (state_q == dbgent_pkg::DBGENT_WAIT_TEST) begin
				win_q <= 25'h0000000;
			end else if (!win_end && state_q != dbgent_pkg::DBGENT_DONE) begin
				win_q <= win_q + 25'h0000001;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			debug_mode  <= 1'b0;
			script_halt <= 1'b0;
			entry_done  <= 1'b0;
		end else begin
			if (state_q == dbgent_pkg::DBGENT_LISTEN && ack_ok) begin
				debug_mode  <= 1'b1;
				script_halt <= 1'b1;
			end
			entry_done <= (state_d == dbgent_pkg::DBGENT_DONE);
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_one_announce;
		@(posedge clk) disable iff (!rst_n)
		tx_go |=> !tx_go [*8];
	endproperty
	a_one_announce: assert property (p_one_announce)
		else $error("Announcement started twice.");

	property p_enter_needs_ack;
		@(posedge clk) disable iff (!rst_n)
		$rose(debug_mode) |-> $past(ack_ok)
		&& $past(state_q) == dbgent_pkg::DBGENT_LISTEN;
	endproperty
	a_enter_needs_ack: assert property (p_enter_needs_ack)
		else $error("Debug mode entered without acknowledgement.");

	property p_halt_follows;
		@(posedge clk) disable iff (!rst_n)
		debug_mode == script_halt;
	endproperty
	a_halt_follows: assert property (p_halt_follows)
		else $error("Halt does not match debug mode.");

	property p_expiry_final;
		@(posedge clk) disable iff (!rst_n)
		(entry_done && !debug_mode) |=> !debug_mode && entry_done;
	endproperty
	a_expiry_final: assert property (p_expiry_final)
		else $error("Debug mode changed after window expiry.");

	property p_tx_frame;
		@(posedge clk) disable iff (!rst_n)
		tx_go |=> !dbg_txd;
	endproperty
	a_tx_frame: assert property (p_tx_frame)
		else $error("Start bit missing after announcement.");

	// Once the announcement has left, the pin stays idle until reset.
	property p_single_frame;
		@(posedge clk) disable iff (!rst_n)
		(sent_q && !tx_busy) |=> !tx_busy;
	endproperty
	a_single_frame: assert property (p_single_frame)
		else $error("Second frame started after the announcement.");

	property p_line_idle;
		@(posedge clk) disable iff (!rst_n)
		(sent_q && !tx_busy) |-> dbg_txd;
	endproperty
	a_line_idle: assert property (p_line_idle)
		else $error("Transmit line not idle after the announcement.");

	property p_quiet_before;
		@(posedge clk) disable iff (!rst_n)
		(state_q == dbgent_pkg::DBGENT_WAIT_TEST)
		|-> dbg_txd && !tx_busy && !debug_mode;
	endproperty
	a_quiet_before: assert property (p_quiet_before)
		else $error("Activity before self-test completion.");

	property p_reject_other;
		@(posedge clk) disable iff (!rst_n)
		(rx.valid && rx.data != dbgent_pkg::ACK_BYTE)
		|=> !$rose(debug_mode);
	endproperty
	a_reject_other: assert property (p_reject_other)
		else $error("Debug mode entered on a foreign byte.");

	property p_reject_frame;
		@(posedge clk) disable iff (!rst_n)
		(rx.valid && rx.frame_err) |=> !$rose(debug_mode);
	endproperty
	a_reject_frame: assert property (p_reject_frame)
		else $error("Debug mode entered on a broken frame.");

	property p_timeout_entry;
		@(posedge clk) disable iff (!rst_n)
		($rose(entry_done) && !debug_mode) |-> $past(win_end);
	endproperty
	a_timeout_entry: assert property (p_timeout_entry)
		else $error("Decision without acknowledgement before window end.");

endmodule // dbgent_entry

// ==== verilog/dbgent_pkg.sv ====
// Purpose: Constants and types for the debug port entry handshake.
// Assumes: 50 MHz system clock, fixed 8N1 framing at 9600 baud.
// Notes:   Shared by the entry controller and its serial transceiver.
package dbgent_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ        = 50000000;
	localparam int unsigned BAUD          = 9600;
	localparam int unsigned BIT_CYC       = CLK_HZ / BAUD;
	localparam int unsigned HALF_CYC      = BIT_CYC / 2;
	localparam int unsigned WINDOW_MS     = 500;
	localparam int unsigned WINDOW_CYC    = (CLK_HZ / 1000) * WINDOW_MS;
	localparam int unsigned DATA_BITS     = 8;

	// ------------------------------------------------------------
	// Byte values
	// ------------------------------------------------------------
	localparam logic [7:0]  ANNOUNCE_BYTE = 8'h00;
	localparam logic [7:0]  ACK_BYTE      = 8'h4f;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		DBGENT_WAIT_TEST = 4'h1,
		DBGENT_ANNOUNCE  = 4'h2,
		DBGENT_LISTEN    = 4'h4,
		DBGENT_DONE      = 4'h8
	} dbgent_state_t;

	typedef struct packed {
		logic       valid;
		logic       frame_err;
		logic [7:0] data;
	} dbgent_rx_t;

endpackage

// ==== verilog/dbgent_uart.sv ====
// Purpose: Fixed 8N1 transceiver at 9600 baud for the debug port.
// Assumes: Receive line already synchronised by the caller.
// Notes:   No rate or framing input exists by design.
`timescale 1ns/100ps
module dbgent_uart (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rst_n,
	// Transmit request
	input  wire logic               tx_start,
	input  wire logic [7:0]         tx_data,
	output wire logic               tx_busy,
	output wire logic               tx_line,
	// Receive side
	input  wire logic               rx_line,
	output dbgent_pkg::dbgent_rx_t  rx_out
);

	localparam logic [15:0] BIT_C  = 16'(dbgent_pkg::BIT_CYC - 1);
	localparam logic [15:0] HALF_C = 16'(dbgent_pkg::HALF_CYC - 1);
	localparam logic [3:0]  LAST   = 4'(dbgent_pkg::DATA_BITS + 1);

	// ------------------------------------------------------------
	// Transmitter
	// ------------------------------------------------------------
	logic [9:0]  tsh_q;
	logic [15:0] tcnt_q;
	logic [3:0]  tbit_q;
	logic        tact_q;
	wire         ttick = (tcnt_q == BIT_C);

	assign tx_busy = tact_q;
	// The shift register idles at all ones, so the pin comes from a flop.
	assign tx_line = tsh_q[0];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tsh_q  <= 10'h3ff;
			tcnt_q <= 16'h0000;
			tbit_q <= 4'h0;
			tact_q <= 1'b0;
		end else if (!tact_q) begin
			if (tx_start) begin
				tsh_q  <= {1'b1, tx_data, 1'b0};
				tcnt_q <= 16'h0000;
				tbit_q <= 4'h0;
				tact_q <= 1'b1;
			end
		end else if (ttick) begin
			tcnt_q <= 16'h0000;
			tsh_q  <= {1'b1, tsh_q[9:1]};
			tbit_q <= tbit_q + 4'h1;
			tact_q <= (tbit_q != LAST);
		end else begin
			tcnt_q <= tcnt_q + 16'h0001;
		end
	end

	// ------------------------------------------------------------
	// Receiver
	// ------------------------------------------------------------
	// Sampling at mid-bit tolerates the usual few percent rate error.
	logic [7:0]  rsh_q;
	logic [15:0] rcnt_q;
	logic [3:0]  rbit_q;
	logic        ract_q;
	wire         rtick = ract_q && (rbit_q == 4'h0 ? rcnt_q == HALF_C
	                                                : rcnt_q == BIT_C);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rsh_q  <= 8'h00;
			rcnt_q <= 16'h0000;
			rbit_q <= 4'h0;
			ract_q <= 1'b0;
			rx_out <= '0;
		end else begin
			rx_out.valid <= 1'b0;
			if (!ract_q) begin
				if (!rx_line) begin
					ract_q <= 1'b1;
					rcnt_q <= 16'h0000;
					rbit_q <= 4'h0;
				end
			end else if (rtick) begin
				rcnt_q <= 16'h0000;
				rbit_q <= rbit_q + 4'h1;
				if (rbit_q == 4'h0 && rx_line) begin
					ract_q <= 1'b0;
				end else if (rbit_q == LAST) begin
					ract_q           <= 1'b0;
					rx_out.valid     <= 1'b1;
					rx_out.frame_err <= !rx_line;
					rx_out.data      <= rsh_q;
				end else if (rbit_q != 4'h0) begin
					rsh_q <= {rx_line, rsh_q[7:1]};
				end
			end else begin
				rcnt_q <= rcnt_q + 16'h0001;
			end
		end
	end

endmodule // dbgent_uart
